// ==== hw/psth_handler.v ====
/*
  status and telemetry command handler of the converter's management
  controller: latched status, telemetry reads, threshold and fault-disable
  blocks, page selection.
  assumes a transport outside that delivers one decoded command per pulse of
  i_CMD_VALID, telemetry and supervisory events already in this clock domain,
  and a link clock from the power stage that toggles while the stage talks.
*/
`timescale 1ns/100ps
`default_nettype none
`include "psth_consts.vh"
// Operation
// - flags stay latched until host clears
// - host clears status bits writing ones
// - power-inactive bit set while stage inactive
// - power-inactive clears after soft-start delay
// - power-inactive and off ignore host clears
// - busy cleared by clear-all or 40h/80h
// - no alert output, host polls only
// - high-side loss always reports undervoltage
// - summary bit when maker or upper set
// - communication bits on bad command/data
// - hardware shutdown on trip or disabled fault
// - page 0 returns stage-reported maker bits
// - link fault after stage silent, once seen
// - link fault cleared by page-0 clear-all
// - page-1 voltages in tenths of volt
// - currents in hundredths, both pages
// - temperature signed, power whole watts
// - ratio unsigned, scaled two^-16
// - page-1 resistance in 10^-5 ohm
// - block write sets thresholds, stage disabled
// - threshold byte above 64h left unchanged
// - disable bits mask supervisory faults only
// - page 00h controller, 01h power stage
// - clear-all clears, active faults re-set
module psth_handler #(
  parameter SOFT_START_CYC = `PSTH_SOFT_START_MS * `PSTH_CLK_KHZ,
  parameter LINK_TO_CYC    = `PSTH_LINK_TO_US * `PSTH_CLK_MHZ
)(
  input  wire        I_CLK,
  input  wire        I_RST,
  input  wire        i_CE,
  input  wire        i_CMD_VALID,
  input  wire        i_CMD_WRITE,
  input  wire [7:0]  i_CMD_CODE,
  input  wire [15:0] i_CMD_DATA,
  input  wire [47:0] i_CMD_BLOCK,
  input  wire        i_XFER_FAULT,
  input  wire        i_BUSY_EVT,
  input  wire [10:0] i_EVT,
  input  wire        i_VHI_LOST,
  input  wire        i_STAGE_ACTIVE,
  input  wire        i_STAGE_EN,
  input  wire        i_LINK_CLK,
  input  wire [15:0] i_VHI,
  input  wire [15:0] i_IHI,
  input  wire [15:0] i_VLO,
  input  wire [15:0] i_ILO,
  input  wire [15:0] i_TEMP,
  input  wire [15:0] i_PLO,
  input  wire [15:0] i_RATIO,
  input  wire [15:0] i_ROUT,
  output reg         o_RSP_VALID,
  output reg         o_RSP_ERR,
  output reg  [47:0] o_RSP_DATA,
  output reg  [7:0]  o_PAGE,
  output reg  [47:0] o_THRESH,
  output reg  [7:0]  o_FAULT_DIS
);
  // the counters are sized for the documented defaults; shorter is fine
  reg  [20:0] ss_cnt;
  reg  [23:0] to_cnt;
  reg         pg_n;
  reg         busy;
  reg  [7:0]  st_iout;
  reg  [7:0]  st_in;
  reg  [7:0]  st_temp;
  reg  [7:0]  st_comm;
  reg  [7:0]  st_maker;
  reg         lk_s1;
  reg         lk_s2;
  reg         lk_s3;
  reg         lk_seen;
  reg  [7:0]  next_iout;
  reg  [7:0]  next_in;
  reg  [7:0]  next_temp;
  reg  [7:0]  next_comm;
  reg  [7:0]  next_maker;
  reg  [47:0] next_thr;
  reg  [47:0] rd_data;
  reg         rd_ok;
  integer     k;

  wire [7:0] code = i_CMD_CODE;
  wire [7:0] d8   = i_CMD_DATA[7:0];
  wire       pg0  = (o_PAGE == `PSTH_PAGE_CTRL);

  // access per command, page and direction; 2 = unknown command
  function [1:0] access;
    input [7:0] c;
    input       p1;
    input       w;
    begin
      case (c)
        `PSTH_CMD_PAGE:  access = 2'd1;
        `PSTH_CMD_CLR:   access = {1'b0, w};
        `PSTH_CMD_SBYTE: access = {1'b0, ~(w & p1)};
        `PSTH_CMD_SWORD: access = {1'b0, ~w};
        `PSTH_CMD_SIOUT,
        `PSTH_CMD_SIN,
        `PSTH_CMD_STEMP,
        `PSTH_CMD_SMAKER: access = {1'b0, ~w | p1};
        `PSTH_CMD_SCOMM: access = {1'b0, ~p1};
        `PSTH_CMD_RIHI,
        `PSTH_CMD_RILO,
        `PSTH_CMD_RTEMP,
        `PSTH_CMD_RPLO:  access = {1'b0, ~w};
        `PSTH_CMD_RVHI,
        `PSTH_CMD_RVLO,
        `PSTH_CMD_RRATIO,
        `PSTH_CMD_RROUT: access = {1'b0, ~w & p1};
        `PSTH_CMD_THR,
        `PSTH_CMD_FDIS:  access = {1'b0, p1};
        default:         access = 2'd2;
      endcase
    end
  endfunction

  // host write-one-to-clear mask for one status command
  function [7:0] w1c;
    input [7:0] target;
    input       go;
    begin
      w1c = (go && code == target) ? d8 : 8'h00;
    end
  endfunction

  wire [1:0] acc     = access(code, ~pg0, i_CMD_WRITE);
  wire       bad_cmd = i_CMD_VALID & acc[1];
  wire       bad_acc = i_CMD_VALID & ~acc[1] & ~acc[0];
  wire       do_wr   = i_CMD_VALID & acc[0] & i_CMD_WRITE;
  wire       clr_all = do_wr & (code == `PSTH_CMD_CLR);
  wire       busy_wr = do_wr & (code == `PSTH_CMD_SBYTE) & pg0 &
                       (d8 == `PSTH_BUSY_CLR_A || d8 == `PSTH_BUSY_CLR_B);
  wire       blk_wr  = do_wr & (code == `PSTH_CMD_THR || code == `PSTH_CMD_FDIS);
  wire       locked  = blk_wr & i_STAGE_EN;
  wire       bad_dat = (do_wr & (code == `PSTH_CMD_PAGE) & (d8 > `PSTH_PAGE_STAGE)) |
                       (do_wr & (code == `PSTH_CMD_SBYTE) & ~busy_wr) |
                       locked;
  wire       thr_go  = do_wr & (code == `PSTH_CMD_THR) & ~i_STAGE_EN;
  wire       dis_go  = do_wr & (code == `PSTH_CMD_FDIS) & ~i_STAGE_EN;

  // disabled supervisory faults drop their status and trip the shutdown bit
  wire ev_vovf = i_EVT[`PSTH_EV_VIN_OVF];
  wire ev_vuvf = i_EVT[`PSTH_EV_VIN_UVF];
  wire ev_iocf = i_EVT[`PSTH_EV_IO_OCF];
  wire ev_otf  = i_EVT[`PSTH_EV_OTF];
  wire ev_utf  = i_EVT[`PSTH_EV_UTF];
  wire [4:0] sup_ev  = {ev_utf, ev_otf, ev_iocf, ev_vuvf, ev_vovf};
  wire [4:0] sup_ok  = sup_ev & ~o_FAULT_DIS[4:0];
  wire       dis_hit = |(sup_ev & o_FAULT_DIS[4:0]);

  // link faults only after the stage has spoken at least once
  wire lk_edge = lk_s2 ^ lk_s3;
  // the count parks at its limit, so the fault stays live until edges return
  wire lk_fail = lk_seen & (to_cnt >= LINK_TO_CYC - 1);

  reg  [7:0] set_iout;
  reg  [7:0] set_in;
  reg  [7:0] set_temp;
  reg  [7:0] set_comm;
  reg  [7:0] set_maker;

  // one set vector per status register, positions named in the header
  always @*
  begin
    set_iout = 8'h00;
    set_in   = 8'h00;
    set_temp = 8'h00;
    set_comm = 8'h00;
    set_iout[`PSTH_IO_OCF]   = sup_ok[2];
    set_iout[`PSTH_IO_OCW]   = i_EVT[`PSTH_EV_IO_OCW];
    set_in[`PSTH_IN_OVF]     = sup_ok[0];
    set_in[`PSTH_IN_OVW]     = i_EVT[`PSTH_EV_VIN_OVW];
    set_in[`PSTH_IN_UVF]     = sup_ok[1] | i_VHI_LOST;
    set_temp[`PSTH_TP_OTF]   = sup_ok[3];
    set_temp[`PSTH_TP_OTW]   = i_EVT[`PSTH_EV_OTW];
    set_temp[`PSTH_TP_UTF]   = sup_ok[4];
    set_comm[`PSTH_CM_CMD]   = bad_cmd | bad_acc;
    set_comm[`PSTH_CM_DATA]  = bad_dat;
    set_comm[`PSTH_CM_OTHER] = i_XFER_FAULT;
  end

  always @*
  begin
    set_maker = 8'h00;
    set_maker[`PSTH_MK_REV]  = i_EVT[`PSTH_EV_REV];
    set_maker[`PSTH_MK_ACS]  = i_EVT[`PSTH_EV_ACS];
    set_maker[`PSTH_MK_HWP]  = i_EVT[`PSTH_EV_HWP] | dis_hit;
    set_maker[`PSTH_MK_LINK] = lk_fail;
  end

  wire [7:0] clr_any = clr_all ? 8'hff : 8'h00;
  reg  [7:0] clr_mk;

  // clear-all lets the link fault go only on the controller page; on the stage page clear-all keeps it
  always @*
  begin
    clr_mk                = clr_any;
    clr_mk[`PSTH_MK_LINK] = clr_all & pg0;
  end

  // set wins over clear, so a fault that is still present re-latches
  always @*
  begin
    next_iout  = (st_iout & ~(clr_any | w1c(`PSTH_CMD_SIOUT, do_wr))) | set_iout;
    next_in    = (st_in & ~(clr_any | w1c(`PSTH_CMD_SIN, do_wr))) | set_in;
    next_temp  = (st_temp & ~(clr_any | w1c(`PSTH_CMD_STEMP, do_wr))) | set_temp;
    next_comm  = (st_comm & ~(clr_any | w1c(`PSTH_CMD_SCOMM, do_wr))) | set_comm;
    next_maker = (st_maker & ~(clr_mk | w1c(`PSTH_CMD_SMAKER, do_wr))) | set_maker;
  end

  // bytes above the ceiling keep the old value
  always @*
  begin
    next_thr = o_THRESH;
    for (k = 0; k < 6; k = k + 1)
      if (i_CMD_BLOCK[k*8 +: 8] <= `PSTH_THR_MAX)
        next_thr[k*8 +: 8] = i_CMD_BLOCK[k*8 +: 8];
  end

  // off and power-inactive are live; host writes never reach them
  wire       off_b = ~i_STAGE_ACTIVE;
  reg  [7:0] hi_b;
  reg  [7:0] sbyte;

  always @*
  begin
    hi_b                  = 8'h00;
    sbyte                 = 8'h00;
    hi_b[`PSTH_SW_IOUT]   = |st_iout;
    hi_b[`PSTH_SW_INPUT]  = |st_in;
    hi_b[`PSTH_SW_MAKER]  = |st_maker;
    hi_b[`PSTH_SW_PGOOD]  = pg_n;
    sbyte[`PSTH_SB_BUSY]  = busy;
    sbyte[`PSTH_SB_OFF]   = off_b;
    sbyte[`PSTH_SB_IOUT]  = st_iout[`PSTH_IO_OCF];
    sbyte[`PSTH_SB_INPUT] = st_in[`PSTH_IN_UVF];
    sbyte[`PSTH_SB_TEMP]  = |st_temp;
    sbyte[`PSTH_SB_COMM]  = |st_comm;
    sbyte[`PSTH_SB_NONE]  = (|st_maker) | (|hi_b);
  end

  // decoded every cycle, latched only for a legal read
  always @*
  begin
    rd_data = 48'h0;
    rd_ok   = 1'b1;
    case (code)
      `PSTH_CMD_PAGE:   rd_data[7:0] = o_PAGE;
      `PSTH_CMD_SBYTE:  rd_data[7:0] = sbyte;
      `PSTH_CMD_SWORD:  rd_data[15:0] = {hi_b, sbyte};
      `PSTH_CMD_SIOUT:  rd_data[7:0] = st_iout;
      `PSTH_CMD_SIN:    rd_data[7:0] = st_in;
      `PSTH_CMD_STEMP:  rd_data[7:0] = st_temp;
      `PSTH_CMD_SCOMM:  rd_data[7:0] = st_comm;
      `PSTH_CMD_SMAKER: rd_data[7:0] = st_maker;
      `PSTH_CMD_RVHI:   rd_data[15:0] = i_VHI;
      `PSTH_CMD_RVLO:   rd_data[15:0] = i_VLO;
      `PSTH_CMD_RIHI:   rd_data[15:0] = i_IHI;
      `PSTH_CMD_RILO:   rd_data[15:0] = i_ILO;
      `PSTH_CMD_RTEMP:  rd_data[15:0] = i_TEMP;
      `PSTH_CMD_RPLO:   rd_data[15:0] = i_PLO;
      `PSTH_CMD_RRATIO: rd_data[15:0] = i_RATIO;
      `PSTH_CMD_RROUT:  rd_data[15:0] = i_ROUT;
      `PSTH_CMD_THR:    rd_data = o_THRESH;
      `PSTH_CMD_FDIS:   rd_data[7:0] = o_FAULT_DIS;
      default:          rd_ok = 1'b0;
    endcase
  end

  // link clock is sampled, never used as a clock
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      lk_s1   <= 1'b0;
      lk_s2   <= 1'b0;
      lk_s3   <= 1'b0;
      lk_seen <= 1'b0;
      to_cnt  <= 24'h0;
    end
    else if (i_CE)
    begin
      lk_s1 <= i_LINK_CLK;
      lk_s2 <= lk_s1;
      lk_s3 <= lk_s2;
      if (lk_edge)
      begin
        lk_seen <= 1'b1;
        to_cnt  <= 24'h0;
      end
      else if (lk_seen && to_cnt < LINK_TO_CYC - 1)
        to_cnt <= to_cnt + 24'h1;
    end
  end

  // power-inactive waits out soft start after activation
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      ss_cnt <= 21'h0;
      pg_n   <= 1'b1;
    end
    else if (i_CE)
    begin
      if (!i_STAGE_ACTIVE)
      begin
        ss_cnt <= 21'h0;
        pg_n   <= 1'b1;
      end
      else if (ss_cnt < SOFT_START_CYC - 1)
        ss_cnt <= ss_cnt + 21'h1;
      else
        pg_n <= 1'b0;
    end
  end

  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      busy        <= 1'b0;
      st_iout     <= 8'h00;
      st_in       <= 8'h00;
      st_temp     <= 8'h00;
      st_comm     <= 8'h00;
      st_maker    <= 8'h00;
      o_PAGE      <= `PSTH_PAGE_CTRL;
      o_THRESH    <= `PSTH_THR_RESET;
      o_FAULT_DIS <= 8'h00;
      o_RSP_VALID <= 1'b0;
      o_RSP_ERR   <= 1'b0;
      o_RSP_DATA  <= 48'h0;
    end
    else if (i_CE)
    begin
      st_iout  <= next_iout;
      st_in    <= next_in;
      st_temp  <= next_temp;
      st_comm  <= next_comm;
      st_maker <= next_maker;
      if (i_BUSY_EVT)
        busy <= 1'b1;
      else if (clr_all || busy_wr)
        busy <= 1'b0;
      if (do_wr && code == `PSTH_CMD_PAGE && d8 <= `PSTH_PAGE_STAGE)
        o_PAGE <= d8;
      if (thr_go)
        o_THRESH <= next_thr;
      if (dis_go)
        o_FAULT_DIS <= i_CMD_BLOCK[7:0];
      o_RSP_VALID <= i_CMD_VALID;
      o_RSP_ERR   <= bad_cmd | bad_acc | bad_dat;
      if (i_CMD_VALID && !i_CMD_WRITE && acc == 2'd1 && rd_ok)
        o_RSP_DATA <= rd_data;
      else if (i_CMD_VALID)
        o_RSP_DATA <= 48'h0;
    end
  end
  // no alert pin and no bus mastering: host learns of faults by polling
endmodule
`default_nettype wire

// ==== shared/psth_consts.vh ====
/*
  constants for the status and telemetry command handler: command codes,
  page values, status bit positions, event vector layout and timing.
  assumes one inclusion per compilation unit; the guard protects against more.
*/
`ifndef PSTH_CONSTS_VH
`define PSTH_CONSTS_VH
`define PSTH_CMD_PAGE   8'h00
`define PSTH_CMD_CLR    8'h03
`define PSTH_CMD_SBYTE  8'h78
`define PSTH_CMD_SWORD  8'h79
`define PSTH_CMD_SIOUT  8'h7b
`define PSTH_CMD_SIN    8'h7c
`define PSTH_CMD_STEMP  8'h7d
`define PSTH_CMD_SCOMM  8'h7e
`define PSTH_CMD_SMAKER 8'h80
`define PSTH_CMD_RVHI   8'h88
`define PSTH_CMD_RIHI   8'h89
`define PSTH_CMD_RVLO   8'h8b
`define PSTH_CMD_RILO   8'h8c
`define PSTH_CMD_RTEMP  8'h8d
`define PSTH_CMD_RPLO   8'h96
`define PSTH_CMD_RRATIO 8'hd1
`define PSTH_CMD_RROUT  8'hd4
`define PSTH_CMD_THR    8'hd5
`define PSTH_CMD_FDIS   8'hd7
`define PSTH_PAGE_CTRL  8'h00
`define PSTH_PAGE_STAGE 8'h01
`define PSTH_BUSY_CLR_A 8'h40
`define PSTH_BUSY_CLR_B 8'h80
`define PSTH_THR_MAX    8'h64
`define PSTH_THR_RESET  48'h646464646464
`define PSTH_EV_VIN_OVF 0
`define PSTH_EV_VIN_OVW 1
`define PSTH_EV_VIN_UVF 2
`define PSTH_EV_IO_OCF  3
`define PSTH_EV_IO_OCW  4
`define PSTH_EV_OTF     5
`define PSTH_EV_OTW     6
`define PSTH_EV_UTF     7
`define PSTH_EV_HWP     8
`define PSTH_EV_ACS     9
`define PSTH_EV_REV     10
`define PSTH_MK_REV     0
`define PSTH_MK_ACS     1
`define PSTH_MK_HWP     2
`define PSTH_MK_LINK    3
`define PSTH_IO_OCF     7
`define PSTH_IO_OCW     5
`define PSTH_IN_OVF     7
`define PSTH_IN_OVW     6
`define PSTH_IN_UVF     4
`define PSTH_TP_OTF     7
`define PSTH_TP_OTW     6
`define PSTH_TP_UTF     4
`define PSTH_CM_CMD     7
`define PSTH_CM_DATA    6
`define PSTH_CM_OTHER   1
`define PSTH_SB_BUSY    7
`define PSTH_SB_OFF     6
`define PSTH_SB_IOUT    4
`define PSTH_SB_INPUT   3
`define PSTH_SB_TEMP    2
`define PSTH_SB_COMM    1
`define PSTH_SB_NONE    0
`define PSTH_SW_IOUT    6
`define PSTH_SW_INPUT   5
`define PSTH_SW_MAKER   4
`define PSTH_SW_PGOOD   3
`define PSTH_SOFT_START_MS 5
`define PSTH_CLK_KHZ       250000
`define PSTH_LINK_TO_US    400
`define PSTH_CLK_MHZ       250
`endif

// ==== bench/psth_handler_properties.sv ====
/*
  checker for the command port, page, threshold and fault-disable outputs.
  assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module psth_handler_properties (
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        i_CE,
  input wire logic        i_CMD_VALID,
  input wire logic        i_CMD_WRITE,
  input wire logic [7:0]  i_CMD_CODE,
  input wire logic [15:0] i_CMD_DATA,
  input wire logic        i_STAGE_EN,
  input wire logic        o_RSP_VALID,
  input wire logic        o_RSP_ERR,
  input wire logic [47:0] o_RSP_DATA,
  input wire logic [7:0]  o_PAGE,
  input wire logic [47:0] o_THRESH,
  input wire logic [7:0]  o_FAULT_DIS
);
  logic go;
  logic wr;
  assign go = i_CE && i_CMD_VALID;
  assign wr = go && i_CMD_WRITE;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  chk_rsp_follows: assert property (go |=> o_RSP_VALID) else $error("no response");
  chk_rsp_quiet: assert property (i_CE && !i_CMD_VALID |=> !o_RSP_VALID) else $error("stray response");
  chk_write_zero: assert property (wr |=> o_RSP_DATA == 48'h0) else $error("write data");
  chk_unknown_err: assert property (go && i_CMD_CODE == 8'h01 |=> o_RSP_ERR) else $error("no error");
  chk_page_range: assert property (o_PAGE <= 8'h01) else $error("bad page");
  chk_page_load: assert property (wr && i_CMD_CODE == 8'h00 && i_CMD_DATA[7:0] <= 8'h01
    |=> o_PAGE == $past(i_CMD_DATA[7:0])) else $error("page load");
  chk_thr_lock: assert property (wr && i_CMD_CODE == 8'hd5 && i_STAGE_EN
    |=> o_RSP_ERR && $stable(o_THRESH)) else $error("locked write");
  chk_thr_only: assert property (!(wr && i_CMD_CODE == 8'hd5) |=> $stable(o_THRESH)) else $error("thr moved");
  chk_thr_ceiling: assert property (o_THRESH[7:0] <= 8'h64 && o_THRESH[15:8] <= 8'h64
    && o_THRESH[23:16] <= 8'h64 && o_THRESH[31:24] <= 8'h64
    && o_THRESH[39:32] <= 8'h64 && o_THRESH[47:40] <= 8'h64) else $error("thr");
  chk_fdis_only: assert property (!(wr && i_CMD_CODE == 8'hd7 && !i_STAGE_EN)
    |=> $stable(o_FAULT_DIS)) else $error("fdis moved");
  cover property (wr && i_CMD_CODE == 8'hd5 && i_STAGE_EN);
  cover property (wr && i_CMD_CODE == 8'h03);
  cover property (o_RSP_VALID && o_RSP_ERR);
endmodule
bind psth_handler psth_handler_properties i_chk (.I_CLK(I_CLK), .I_RST(I_RST), .i_CE(i_CE),
  .i_CMD_VALID(i_CMD_VALID), .i_CMD_WRITE(i_CMD_WRITE), .i_CMD_CODE(i_CMD_CODE),
  .i_CMD_DATA(i_CMD_DATA), .i_STAGE_EN(i_STAGE_EN), .o_RSP_VALID(o_RSP_VALID),
  .o_RSP_ERR(o_RSP_ERR), .o_RSP_DATA(o_RSP_DATA), .o_PAGE(o_PAGE), .o_THRESH(o_THRESH),
  .o_FAULT_DIS(o_FAULT_DIS));
`default_nettype wire

// ==== bench/psth_link_src.sv ====
/*
  power stage link source: toggles the link clock while the stage talks.
  assumes the handler samples it with its own clock.
*/
`timescale 1ns/100ps
`default_nettype none
module psth_link_src (
  input  wire logic i_talk,
  output var  logic o_lclk
);
  // stands still between frames, so silence looks like a dead stage
  initial
  begin
    o_lclk = 1'b0;
    #0.7;
    forever
      #40 if (i_talk) o_lclk = ~o_lclk;
  end
endmodule
`default_nettype wire

// ==== bench/psth_handler_tb.sv ====
/*
  self-checking bench for the status and telemetry handler.
  assumes short soft-start and link timeout counts set below.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module psth_handler_tb;
  logic        clk = 0, rst = 1, v = 0, wr = 0, xf = 0, busy = 0, vlost = 0, act = 0, en = 0, talk = 0, ce = 1;
  logic [7:0]  code = 0;
  logic [15:0] dat = 0, r = 16'd97;
  logic [47:0] blk = 0, o_dat, o_thr;
  logic [10:0] evt = 0;
  logic [15:0] tel [8];
  logic [7:0]  tc [8] = '{8'h88, 8'h89, 8'h8b, 8'h8c, 8'h8d, 8'h96, 8'hd1, 8'hd4};
  logic [7:0]  o_pg, o_fd;
  logic        o_rv, o_err, lclk;
  logic [48:0] exp_q [$];
  logic [48:0] x;
  int          err_total = 0, samples_checked = 0, i;
  always #2 clk = ~clk;
  psth_link_src i_src (.i_talk(talk), .o_lclk(lclk));
  psth_handler #(.SOFT_START_CYC(20), .LINK_TO_CYC(30)) i_dut (.I_CLK(clk), .I_RST(rst), .i_CE(ce),
    .i_CMD_VALID(v), .i_CMD_WRITE(wr), .i_CMD_CODE(code), .i_CMD_DATA(dat), .i_CMD_BLOCK(blk),
    .i_XFER_FAULT(xf), .i_BUSY_EVT(busy), .i_EVT(evt), .i_VHI_LOST(vlost), .i_STAGE_ACTIVE(act),
    .i_STAGE_EN(en), .i_LINK_CLK(lclk), .i_VHI(tel[0]), .i_IHI(tel[1]), .i_VLO(tel[2]), .i_ILO(tel[3]),
    .i_TEMP(tel[4]), .i_PLO(tel[5]), .i_RATIO(tel[6]), .i_ROUT(tel[7]), .o_RSP_VALID(o_rv),
    .o_RSP_ERR(o_err), .o_RSP_DATA(o_dat), .o_PAGE(o_pg), .o_THRESH(o_thr), .o_FAULT_DIS(o_fd));
  function automatic [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [47:0] b,
    input logic e, input logic [47:0] ed);
    @(negedge clk);
    {v, wr, code, dat, blk} = {1'b1, w, c, d, b};
    exp_q.push_back({e, ed});
    @(negedge clk);
    v = 0;
  endtask
  task automatic tick(ref logic s);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask
  task automatic final_report;
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // results land one cycle after the request, so the oldest note always matches
  always @(negedge clk)
    if (o_rv === 1'b1)
    begin
      x = exp_q.pop_front();
      `CHK("err", x[48], o_err)
      `CHK("data", x[47:0], o_dat)
    end
  initial
  begin
    #100000;
    err_total++;
    final_report();
  end
  initial
  begin
    for (i = 0; i < 8; i++) tel[i] = 0;
    repeat (12) @(negedge clk);
    rst = 0;
    cmd(0, 8'h79, 0, 0, 0, 48'h0841);
    for (i = 0; i < 3; i++)
    begin
      tick(busy);
      cmd(0, 8'h78, 0, 0, 0, 48'hc1);
      cmd(1, i == 2 ? 8'h03 : 8'h78, i ? 16'h40 : 16'h80, 0, 0, 0);
      cmd(0, 8'h78, 0, 0, 0, 48'h41);
    end
    cmd(0, 8'h80, 0, 0, 0, 0);
    cmd(1, 8'h79, 16'hff, 0, 1, 0);
    cmd(1, 8'h78, 16'h41, 0, 1, 0);
    cmd(0, 8'h78, 0, 0, 0, 48'h43);
    cmd(1, 8'h7e, 16'hff, 0, 0, 0);
    act = 1;
    repeat (10) @(negedge clk);
    cmd(0, 8'h79, 0, 0, 0, 48'h0801);
    repeat (15) @(negedge clk);
    cmd(0, 8'h79, 0, 0, 0, 0);
    cmd(1, 8'h00, 16'h01, 0, 0, 0);
    `CHK("page", 8'h01, o_pg)
    cmd(1, 8'hd7, 0, 48'h02, 0, 0);
    `CHK("fdis", 8'h02, o_fd)
    evt[2] = 1;
    @(negedge clk);
    evt = 0;
    cmd(0, 8'h7c, 0, 0, 0, 0);
    cmd(0, 8'h80, 0, 0, 0, 48'h04);
    cmd(0, 8'h79, 0, 0, 0, 48'h1001);
    tick(vlost);
    cmd(0, 8'h7c, 0, 0, 0, 48'h10);
    evt[5] = 1;
    @(negedge clk);
    evt = 0;
    cmd(0, 8'h78, 0, 0, 0, 48'h0d);
    cmd(1, 8'h7d, 16'hff, 0, 0, 0);
    cmd(0, 8'h78, 0, 0, 0, 48'h09);
    cmd(1, 8'h03, 0, 0, 0, 0);
    cmd(0, 8'h79, 0, 0, 0, 0);
    cmd(1, 8'hd5, 0, 48'h6550ff006432, 0, 0);
    @(negedge clk);
    `CHK("thr", 48'h645064006432, o_thr)
    en = 1;
    cmd(1, 8'hd5, 0, 0, 1, 0);
    cmd(1, 8'hd7, 0, 0, 1, 0);
    @(negedge clk);
    `CHK("thr", 48'h645064006432, o_thr)
    `CHK("fdis", 8'h02, o_fd)
    en = 0;
    for (i = 0; i < 8; i++)
    begin
      r = lfsr(r);
      tel[i] = r;
    end
    for (i = 0; i < 8; i++) cmd(0, tc[i], 0, 0, 0, {32'h0, tel[i]});
    cmd(1, 8'h00, 0, 0, 0, 0);
    for (i = 0; i < 8; i++)
      cmd(0, tc[i], 0, 0, i == 0 || i == 2 || i > 5,
          (i == 0 || i == 2 || i > 5) ? 0 : tel[i]);
    cmd(0, 8'h01, 0, 0, 1, 0);
    cmd(1, 8'h00, 16'h02, 0, 1, 0);
    `CHK("page", 8'h00, o_pg)
    cmd(1, 8'h7e, 16'hff, 0, 0, 0);
    // a busy pulse while the enable is low must leave no trace in the next read
    ce = 0;
    tick(busy);
    ce = 1;
    tick(xf);
    cmd(0, 8'h78, 0, 0, 0, 48'h02);
    talk = 1;
    repeat (60) @(negedge clk);
    talk = 0;
    repeat (60) @(negedge clk);
    cmd(0, 8'h80, 0, 0, 0, 48'h08);
    // the stage talks again, so a clear is not undone by a live fault
    talk = 1;
    repeat (15) @(negedge clk);
    cmd(1, 8'h00, 16'h01, 0, 0, 0);
    cmd(1, 8'h03, 0, 0, 0, 0);
    cmd(0, 8'h80, 0, 0, 0, 48'h08);
    cmd(1, 8'h00, 16'h00, 0, 0, 0);
    cmd(1, 8'h03, 0, 0, 0, 0);
    cmd(0, 8'h80, 0, 0, 0, 0);
    repeat (3) @(negedge clk);
    `CHK("pending", 0, exp_q.size())
    final_report();
  end
endmodule
`default_nettype wire
